//--- hdl/scs_seq.v
// Purpose: scan sequencer that closes list channels and handshakes with an external meter
// Assumes: one 100 MHz clock; meter pins are asynchronous
// Notes:   configuration and list inputs come from same-clock logic
//
// Functional notes
// - Run request enters wait state until the trigger condition occurs.
// - On trigger, first list channel closes before any meter trigger.
// - After closing, channel-closed output pulses low for about 7 us.
// - Channel-closed pulses are spaced so at most 1000 occur per second.
// - Valid advance opens current channel, closes next, pulses again.
// - Close, trigger, advance repeats until every list channel is scanned.
// - Handshake needs external falling-edge advance and non-external trigger.
// - External trigger with external advance is rejected.
// - Manual trigger with single-step advance is rejected.
// - Two-wire always allowed; four-wire only on low channels of certain modules.
// - Each list entry holds channel number, wiring mode and delay.

`include "scs_defines.vh"

module scs_seq #(
	parameter LIST_AW      = 6,
	parameter DLY_W        = 16,
	parameter PULSE_CYC    = `SCS_PULSE_CYC,
	parameter RATE_CYC     = `SCS_RATE_CYC,
	parameter US_CYC       = `SCS_US_CYC
) (
	// Clock and reset
	input  wire                i_clk,
	input  wire                i_sys_rst,
	// Run control and configuration
	input  wire                i_run_stop,
	input  wire [1:0]          i_trig_mode,
	input  wire [1:0]          i_adv_src,
	input  wire                i_adv_rising,
	input  wire                i_man_trig,
	input  wire                i_step,
	input  wire [7:0]          i_scan_cycles,
	input  wire [1:0]          i_card_type,
	// Scan list write port
	input  wire                i_list_we,
	input  wire [LIST_AW-1:0]  i_list_addr,
	input  wire [6:0]          i_list_chan,
	input  wire                i_list_four_wire_entry,
	input  wire [DLY_W-1:0]    i_list_dly_us,
	input  wire [LIST_AW:0]    i_list_len,
	// Meter pins
	input  wire                i_ext_trig_n,
	input  wire                i_measurement_complete_pulse_n,
	output reg                 o_chan_closed_n,
	// Relay drive
	output reg                 o_relay_close,
	output reg  [6:0]          o_relay_chan,
	output reg                 o_relay_four_wire,
	// Status
	output reg                 o_waiting,
	output reg                 o_busy,
	output reg                 o_done,
	output reg                 o_cfg_err,
	output reg                 o_entry_rej,
	output reg  [7:0]          o_cycle_cnt
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE  = 3'h0;
	localparam ST_WAIT  = 3'h1;
	localparam ST_SETTL = 3'h2;
	localparam ST_PULSE = 3'h3;
	localparam ST_ADV   = 3'h4;
	localparam ST_OPEN  = 3'h5;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	function cfg_bad;
		input [1:0] tm;
		input [1:0] as;
		begin
			cfg_bad = (tm == `SCS_TRIG_EXT && as == `SCS_ADV_EXT) ||
				(tm == `SCS_TRIG_MAN && as == `SCS_ADV_SINGLE) ||
				(tm == `SCS_TRIG_RSV) || (as == `SCS_ADV_RSV);
		end
	endfunction

	function four_wire_ok;
		input [1:0] card;
		input [6:0] chan;
		begin
			if (card == `SCS_CARD_A) begin
				four_wire_ok = chan < `SCS_4W_LIM_A;
			end else if (card == `SCS_CARD_B || card == `SCS_CARD_C) begin
				four_wire_ok = chan < `SCS_4W_LIM_BC;
			end else begin
				four_wire_ok = 1'b0;
			end
		end
	endfunction

	// ----------------------------------------
	// Scan list
	// ----------------------------------------
	reg  [6:0]        list_chan [0:(1<<LIST_AW)-1];
	reg               list_4w   [0:(1<<LIST_AW)-1];
	reg  [DLY_W-1:0]  list_dly  [0:(1<<LIST_AW)-1];
	wire              entry_ok = !i_list_four_wire_entry || four_wire_ok(i_card_type, i_list_chan);

	// No reset on the array: contents are valid only once written
	always @(posedge i_clk) begin
		if (i_list_we && entry_ok) begin
			list_chan[i_list_addr] <= i_list_chan;
			list_4w[i_list_addr]   <= i_list_four_wire_entry;
			list_dly[i_list_addr]  <= i_list_dly_us;
		end
	end

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_entry_rej <= 1'b0;
			o_cfg_err   <= 1'b0;
		end else begin
			if (i_list_we) begin
				o_entry_rej <= !entry_ok;
			end
			o_cfg_err <= cfg_bad(i_trig_mode, i_adv_src);
		end
	end

	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	reg  [2:0] trig_sync;
	reg  [2:0] adv_sync;

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			trig_sync <= 3'h7;
			adv_sync  <= 3'h7;
		end else begin
			trig_sync <= {trig_sync[1:0], i_ext_trig_n};
			adv_sync  <= {adv_sync[1:0], i_measurement_complete_pulse_n};
		end
	end

	wire trig_fall = trig_sync[2] && !trig_sync[1];
	wire adv_fall  = adv_sync[2] && !adv_sync[1];
	wire adv_rise  = !adv_sync[2] && adv_sync[1];
	// Falling edge is the handshake setting; rising kept for other meters
	wire adv_edge  = i_adv_rising ? adv_rise : adv_fall;

	// ----------------------------------------
	// Pulse spacing
	// ----------------------------------------
	// Gap counter saturates so a long wait never wraps into a short gap
	reg  [23:0] gap_cnt;
	wire        gap_ok = gap_cnt >= RATE_CYC[23:0];

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	reg  [2:0]        state;
	reg  [LIST_AW:0]  idx;
	reg  [DLY_W-1:0]  us_left;
	reg  [15:0]       sub_cnt;
	reg  [15:0]       pulse_cnt;
	wire [LIST_AW-1:0] ridx = idx[LIST_AW-1:0];
	wire              last = (idx + 1'b1) >= i_list_len;
	wire              cycles_done = (i_scan_cycles != 8'h00) && (o_cycle_cnt + 8'h01 >= i_scan_cycles);

	reg trig_hit;
	always @* begin
		if (i_trig_mode == `SCS_TRIG_IMM) begin
			trig_hit = 1'b1;
		end else if (i_trig_mode == `SCS_TRIG_EXT) begin
			trig_hit = trig_fall;
		end else if (i_trig_mode == `SCS_TRIG_MAN) begin
			trig_hit = i_man_trig;
		end else begin
			trig_hit = 1'b0;
		end
	end

	reg adv_hit;
	always @* begin
		if (i_adv_src == `SCS_ADV_AUTO) begin
			adv_hit = 1'b1;
		end else if (i_adv_src == `SCS_ADV_EXT) begin
			adv_hit = adv_edge;
		end else if (i_adv_src == `SCS_ADV_SINGLE) begin
			adv_hit = i_step;
		end else begin
			adv_hit = 1'b0;
		end
	end

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state             <= ST_IDLE;
			idx               <= {(LIST_AW+1){1'b0}};
			us_left           <= {DLY_W{1'b0}};
			sub_cnt           <= 16'h0000;
			pulse_cnt         <= 16'h0000;
			gap_cnt           <= 24'hff_ffff;
			o_chan_closed_n   <= 1'b1;
			o_relay_close     <= 1'b0;
			o_relay_chan      <= 7'h00;
			o_relay_four_wire <= 1'b0;
			o_waiting         <= 1'b0;
			o_busy            <= 1'b0;
			o_done            <= 1'b0;
			o_cycle_cnt       <= 8'h00;
		end else begin
			if (!gap_ok) begin
				gap_cnt <= gap_cnt + 24'h00_0001;
			end
			if (i_run_stop && state != ST_IDLE) begin
				// Stop aborts the scan and opens whatever is closed
				state           <= ST_IDLE;
				o_relay_close   <= 1'b0;
				o_chan_closed_n <= 1'b1;
				o_waiting       <= 1'b0;
				o_busy          <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					if (i_run_stop && !cfg_bad(i_trig_mode, i_adv_src) && i_list_len != 0) begin
						state       <= ST_WAIT;
						o_waiting   <= 1'b1;
						o_busy      <= 1'b1;
						o_done      <= 1'b0;
						o_cycle_cnt <= 8'h00;
					end
				end
				ST_WAIT: begin
					if (trig_hit) begin
						// First channel closes before any meter trigger
						idx               <= {(LIST_AW+1){1'b0}};
						o_relay_chan      <= list_chan[0];
						o_relay_four_wire <= list_4w[0];
						o_relay_close     <= 1'b1;
						us_left           <= list_dly[0];
						sub_cnt           <= 16'h0000;
						o_waiting         <= 1'b0;
						state             <= ST_SETTL;
					end
				end
				ST_SETTL: begin
					if (us_left == {DLY_W{1'b0}}) begin
						if (gap_ok) begin
							o_chan_closed_n <= 1'b0;
							pulse_cnt       <= 16'h0000;
							gap_cnt         <= 24'h00_0000;
							state           <= ST_PULSE;
						end
					end else if (sub_cnt == US_CYC[15:0] - 16'h0001) begin
						sub_cnt <= 16'h0000;
						us_left <= us_left - 1'b1;
					end else begin
						sub_cnt <= sub_cnt + 16'h0001;
					end
				end
				ST_PULSE: begin
					if (pulse_cnt == PULSE_CYC[15:0] - 16'h0001) begin
						o_chan_closed_n <= 1'b1;
						state           <= ST_ADV;
					end else begin
						pulse_cnt <= pulse_cnt + 16'h0001;
					end
				end
				ST_ADV: begin
					// Advances are acted on only here; elsewhere they fall away
					if (adv_hit) begin
						o_relay_close <= 1'b0;
						state         <= ST_OPEN;
					end
				end
				ST_OPEN: begin
					if (!last) begin
						idx               <= idx + 1'b1;
						o_relay_chan      <= list_chan[ridx + 1'b1];
						o_relay_four_wire <= list_4w[ridx + 1'b1];
						o_relay_close     <= 1'b1;
						us_left           <= list_dly[ridx + 1'b1];
						sub_cnt           <= 16'h0000;
						state             <= ST_SETTL;
					end else if (cycles_done) begin
						o_cycle_cnt <= o_cycle_cnt + 8'h01;
						o_done      <= 1'b1;
						o_busy      <= 1'b0;
						state       <= ST_IDLE;
					end else begin
						o_cycle_cnt <= o_cycle_cnt + 8'h01;
						o_waiting   <= 1'b1;
						state       <= ST_WAIT;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

//--- hdl/scs_defines.vh
// Purpose: constants for the scan channel handshake sequencer
// Assumes: 100 MHz clock
// Notes:   times in ns, cycle counts derived from them
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCS_CLK_NS        10
`define SCS_PULSE_NS      7000
`define SCS_PULSE_CYC     (`SCS_PULSE_NS / `SCS_CLK_NS)
`define SCS_RATE_NS       1000000
`define SCS_RATE_CYC      ((`SCS_RATE_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_US_NS         1000
`define SCS_US_CYC        (`SCS_US_NS / `SCS_CLK_NS)

// ----------------------------------------
// Trigger modes
// ----------------------------------------
`define SCS_TRIG_IMM      2'h0
`define SCS_TRIG_EXT      2'h1
`define SCS_TRIG_MAN      2'h2
`define SCS_TRIG_RSV      2'h3

// ----------------------------------------
// Advance sources
// ----------------------------------------
`define SCS_ADV_AUTO      2'h0
`define SCS_ADV_EXT       2'h1
`define SCS_ADV_SINGLE    2'h2
`define SCS_ADV_RSV       2'h3

// ----------------------------------------
// Module types and four-wire limits
// ----------------------------------------
`define SCS_CARD_A        2'h0
`define SCS_CARD_B        2'h1
`define SCS_CARD_C        2'h2
`define SCS_CARD_NONE     2'h3
`define SCS_4W_LIM_A      7'h10
`define SCS_4W_LIM_BC     7'h0a

`endif

//--- sim/scs_seq_sva.sv
// Purpose: port checks for the scan sequencer
// Assumes: one clock, async active-high reset
// Notes:   counters replace long repetitions
module scs_seq_sva #(parameter PULSE_CYC = 7, parameter RATE_CYC = 50) (
	input wire logic       i_clk, i_sys_rst, i_run_stop,
	input wire logic [1:0] i_trig_mode, i_adv_src,
	input wire logic [6:0] i_list_len, o_relay_chan,
	input wire logic       o_chan_closed_n, o_relay_close, o_waiting, o_busy, o_done, o_cfg_err
);
	timeunit 1ns;
	timeprecision 1ps;
	int   low_n;
	int   gap;
	logic prv;
	// Gap starts saturated so the first pulse is free
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			low_n <= 0;
			gap   <= RATE_CYC;
			prv   <= 1'b1;
		end else begin
			prv   <= o_chan_closed_n;
			low_n <= o_chan_closed_n ? 0 : low_n + 1;
			gap   <= (prv && !o_chan_closed_n) ? 1 : (gap < RATE_CYC ? gap + 1 : gap);
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	run_wait_a: assert property (
		!o_busy && i_run_stop && !o_cfg_err && i_list_len != 7'h00 && $stable(i_trig_mode)
		&& $stable(i_adv_src) |=> o_waiting && o_busy) else $error("run did not wait");
	close_first_a: assert property ($fell(o_chan_closed_n) |-> $past(o_relay_close))
		else $error("pulse before close");
	pulse_closed_a: assert property (!o_chan_closed_n |-> o_relay_close)
		else $error("pulse with relay open");
	pulse_width_a: assert property ($rose(o_chan_closed_n) |-> low_n == PULSE_CYC)
		else $error("pulse width wrong");
	pulse_rate_a: assert property ($fell(o_chan_closed_n) |-> gap >= RATE_CYC)
		else $error("pulses too close");
	chan_hold_a: assert property (o_relay_close && $past(o_relay_close) |-> $stable(o_relay_chan))
		else $error("channel moved while closed");
	done_open_a: assert property ($rose(o_done) |-> !o_relay_close && !o_busy)
		else $error("done with relay closed");
	stop_open_a: assert property (o_busy && i_run_stop |=> !o_relay_close)
		else $error("stop left relay closed");
	bad_cfg_a: assert property (
		(i_trig_mode == 2'h1 && i_adv_src == 2'h1) || (i_trig_mode == 2'h2 && i_adv_src == 2'h2)
		|=> o_cfg_err) else $error("bad config accepted");
	cover property ($fell(o_chan_closed_n));
	cover property ($rose(o_done));
	cover property (o_busy && i_run_stop);
endmodule

bind scs_seq scs_seq_sva #(.PULSE_CYC(PULSE_CYC), .RATE_CYC(RATE_CYC)) u_sva (.i_clk, .i_sys_rst,
	.i_run_stop, .i_trig_mode, .i_adv_src, .i_list_len, .o_relay_chan, .o_chan_closed_n, .o_relay_close,
	.o_waiting, .o_busy, .o_done, .o_cfg_err);

//--- sim/scs_meter.sv
// Purpose: behavioural meter on the trigger handshake
// Assumes: done pin idles high and is always driven
// Notes:   a trigger during a measurement is missed, as on a busy meter
module scs_meter #(parameter int MEAS_NS = 100) (
	input  wire logic i_trig_n,
	output logic      o_done_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_done_n = 1'b1;
	always @(negedge i_trig_n) begin
		#MEAS_NS;
		o_done_n = 1'b0;
		#2000;
		o_done_n = 1'b1;
	end
endmodule

//--- sim/scs_seq_tb_top.sv
// Purpose: self-checking bench for the scan sequencer
// Assumes: shortened pulse, rate and delay counts
// Notes:   stray advances come from a gate on the meter pin
module scs_seq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clk = 0, i_sys_rst = 1, i_run_stop = 0, i_man_trig = 0, i_list_we = 0, stray_n = 1;
	logic       i_list_four_wire_entry = 0, mdone_n, rc_q = 0;
	logic       ext_trig_n = 1, i_step = 0;
	logic [1:0] i_trig_mode = 0, i_adv_src = 1, i_card_type = 0;
	logic [7:0] i_scan_cycles = 8'h01, o_cycle_cnt;
	logic [5:0] i_list_addr = 0;
	logic [6:0] i_list_chan = 0, i_list_len = 0, o_relay_chan;
	logic [15:0] i_list_dly_us = 0;
	logic       o_chan_closed_n, o_relay_close, o_relay_four_wire, o_waiting, o_busy, o_done, o_cfg_err, o_entry_rej;
	int         bad_count = 0, comparisons = 0, pulses = 0, n, p0, s0;
	logic [7:0] seen [$];
	logic [7:0] exp_q [3] = '{8'h83, 8'h05, 8'h07};
	logic [6:0] ch [4] = '{7'h09, 7'h0a, 7'h0f, 7'h10};

	always #5 i_clk = ~i_clk;
	always @(negedge o_chan_closed_n) pulses++;
	always @(posedge i_clk) begin
		rc_q <= o_relay_close;
		if (o_relay_close && !rc_q) seen.push_back({o_relay_four_wire, o_relay_chan});
	end

	scs_seq #(.PULSE_CYC(7), .RATE_CYC(300), .US_CYC(2)) u_dut (.i_clk, .i_sys_rst, .i_run_stop,
		.i_trig_mode, .i_adv_src, .i_adv_rising(1'b0), .i_man_trig, .i_step, .i_scan_cycles,
		.i_card_type, .i_list_we, .i_list_addr, .i_list_chan, .i_list_four_wire_entry, .i_list_dly_us,
		.i_list_len, .i_ext_trig_n(ext_trig_n), .i_measurement_complete_pulse_n(mdone_n & stray_n),
		.o_chan_closed_n, .o_relay_close, .o_relay_chan, .o_relay_four_wire, .o_waiting, .o_busy,
		.o_done, .o_cfg_err, .o_entry_rej, .o_cycle_cnt);
	scs_meter u_meter (.i_trig_n(o_chan_closed_n), .o_done_n(mdone_n));

	// --------------------------------
	// Tasks
	// --------------------------------
	task check(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("counts: comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task wr(input logic [5:0] a, input logic [6:0] c, input logic f, input logic [15:0] d, input logic x);
		@(posedge i_clk);
		i_list_we <= 1'b1;
		i_list_addr <= a;
		i_list_chan <= c;
		i_list_four_wire_entry <= f;
		i_list_dly_us <= d;
		@(posedge i_clk);
		i_list_we <= 1'b0;
		#1 check({7'h00, o_entry_rej}, {7'h00, x});
	endtask
	// One-cycle pulse on manual trigger or run/stop
	task strobe(input logic m);
		@(posedge i_clk);
		if (m) i_man_trig <= 1'b1;
		else i_run_stop <= 1'b1;
		@(posedge i_clk);
		i_man_trig <= 1'b0;
		i_run_stop <= 1'b0;
	endtask

	initial begin
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			@(posedge i_clk);
			i_trig_mode <= k[3:2];
			i_adv_src <= k[1:0];
			repeat (2) @(posedge i_clk);
			#1 check({7'h00, o_cfg_err}, {7'h00, k == 5 || k == 10 || k[3:2] == 3 || k[1:0] == 3});
		end
		$display("test config done");
		for (int k = 0; k < 16; k++) begin
			@(posedge i_clk);
			i_card_type <= k[3:2];
			wr(6'h3f, ch[k[1:0]], 1'b1, 16'h0000, ch[k[1:0]] >= (k < 4 ? 16 : k > 11 ? 0 : 10));
		end
		wr(6'h3f, 7'h64, 1'b0, 16'h0000, 1'b0);
		$display("test wiring done");
		@(posedge i_clk);
		i_card_type <= 2'h0;
		i_trig_mode <= 2'h2;
		i_adv_src <= 2'h1;
		wr(6'h00, 7'h03, 1'b1, 16'h0000, 1'b0);
		wr(6'h01, 7'h05, 1'b0, 16'h0001, 1'b0);
		wr(6'h02, 7'h07, 1'b0, 16'h0000, 1'b0);
		@(posedge i_clk);
		i_list_len <= 7'h03;
		strobe(1'b0);
		@(posedge i_clk);
		stray_n <= 1'b0;
		repeat (200) @(posedge i_clk);
		stray_n <= 1'b1;
		repeat (20) @(posedge i_clk);
		#1 check({6'h00, o_waiting, o_relay_close}, 8'h02);
		strobe(1'b1);
		for (n = 0; n < 5000 && o_done !== 1'b1; n++) @(posedge i_clk);
		#1 check({7'h00, o_done}, 8'h01);
		check(8'(pulses), 8'h03);
		check(8'(seen.size()), 8'h03);
		foreach (exp_q[i]) check(seen[i], exp_q[i]);
		check(o_cycle_cnt, 8'h01);
		check({6'h00, o_busy, o_relay_close}, 8'h00);
		$display("test scan done");
		strobe(1'b0);
		repeat (5) @(posedge i_clk);
		#1 check({7'h00, o_waiting}, 8'h01);
		// Abort with a channel closed; spacing keeps the pulse from starting
		strobe(1'b1);
		#1 check({7'h00, o_relay_close}, 8'h01);
		strobe(1'b0);
		repeat (2) @(posedge i_clk);
		#1 check({6'h00, o_busy, o_relay_close}, 8'h00);
		$display("test abort done");
		// External trigger, single-step advance, two passes
		@(posedge i_clk);
		i_trig_mode <= 2'h1;
		i_adv_src <= 2'h2;
		i_scan_cycles <= 8'h02;
		repeat (2) @(posedge i_clk);
		p0 = pulses;
		s0 = seen.size();
		strobe(1'b0);
		for (int p = 0; p < 2; p++) begin
			repeat (3) @(posedge i_clk);
			#1 check({o_waiting, o_cycle_cnt[6:0]}, {1'b1, 7'(p)});
			@(posedge i_clk);
			ext_trig_n <= 1'b0;
			repeat (3) @(posedge i_clk);
			ext_trig_n <= 1'b1;
			for (int e = 0; e < 3; e++) begin
				for (n = 0; n < 1000 && pulses < p0 + 3 * p + e + 1; n++) @(posedge i_clk);
				repeat (12) @(posedge i_clk);
				i_step <= 1'b1;
				@(posedge i_clk);
				i_step <= 1'b0;
			end
		end
		for (n = 0; n < 50 && o_done !== 1'b1; n++) @(posedge i_clk);
		#1 check({o_done, o_cycle_cnt[6:0]}, 8'h82);
		check(8'(pulses - p0), 8'h06);
		check(8'(seen.size() - s0), 8'h06);
		for (int i = 0; i < 6; i++) check(seen[s0 + i], exp_q[i % 3]);
		$display("test external trigger done");
		complete_run;
	end
endmodule
